// File: pll_div_consts.svh
`ifndef PLL_DIV_CONSTS_SVH
`define PLL_DIV_CONSTS_SVH

// Register byte offsets.
`define OFS_MULT 8'h00
`define OFS_DIV_ONE 8'h04
`define OFS_DIV_TWO 8'h08
`define OFS_DIV_THREE 8'h0c
`define OFS_DIV_OBS 8'h10
`define OFS_DIV_BYPASS 8'h14
`define OFS_CLK_ENABLE 8'h18
`define OFS_PLL_CTRL 8'h1c
`define OFS_COMMAND 8'h20

// Field positions and widths.
`define FIELD_W 5
`define ENABLE_BIT 15
`define OBS_ENABLE_BIT 0
`define PLL_MODE_BIT 0
`define COMMAND_BIT 0
`define NUM_DIV 5

// Divider slots.
`define DIV_ONE 0
`define DIV_TWO 1
`define DIV_THREE 2
`define DIV_OBS 3
`define DIV_BYPASS 4
`define NUM_SYS_DIV 3

// Reset values, first and second controller instance.
`define MULT_RST_FIRST 5'h10
`define MULT_RST_SECOND 5'h13
`define DIV_ONE_RST_FIRST 5'h00
`define DIV_ONE_RST_SECOND 5'h01
`define DIV_TWO_RST_FIRST 5'h02
`define DIV_TWO_RST_SECOND 5'h09
`define DIV_THREE_RST 5'h00
`define DIV_OBS_RST 5'h00
`define BYPASS_RST_FIRST 5'h00
`define BYPASS_RST_SECOND 5'h01
`define ENABLE_RST 5'h17

`endif

// File: pll_div_pkg.sv
package pll_div_pkg;
    `include "pll_div_consts.svh"

    typedef logic [`FIELD_W-1:0] ratio_t;

    typedef struct packed {
        ratio_t mult;
        logic [`FIELD_W:0] factor;
        logic [`NUM_DIV-1:0][`FIELD_W-1:0] ratio;
        logic [`NUM_DIV-1:0][`FIELD_W-1:0] act;
        logic [`NUM_DIV-1:0][`FIELD_W-1:0] cnt;
        logic [`NUM_DIV-1:0] en;
        logic [`NUM_DIV-1:0] tick;
        logic obs_ck_en;
        logic pll_mode;
        logic go;
        logic [31:0] rd_data;
    } state_t;
endpackage : pll_div_pkg

// File: pll_multiplier_and_clock_dividers.sv
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/100ps
// Overview of operation
// R1: The PLL is asked to multiply the reference clock by the multiplier field plus one.
// R2: After reset the multiplier field is 10h in the first instance and 13h in the second.
// R3: Each divider divides its source by its ratio field plus one, so zero passes it through.
// R4: The first divider makes system clock one from the PLL side, enable bit 15, ratio bits 4-0.
// R5: After reset the first divider ratio is 0 in the first instance and 1 in the second.
// R6: The second divider makes system clock two from the PLL side, its enable set after reset.
// R7: After reset the second divider ratio is 2h in the first instance and 9h in the second.
// R8: The third divider makes system clock three in the first instance only.
// R9: The observation divider divides the reference clock and drives the output pin in instance one.
// R10: Software programs the observation divider only on the first instance. The code accepts observation divider writes on the second instance too.
// R11: The observation clock runs only while its divider enable and its clock enable are both set.
// R12: The bypass divider makes the bypass system clock from the reference, enable set after reset.
// R13: After reset the bypass ratio is 0 in the first instance and 1 in the second.
// R14: New system divider ratios take effect only when software writes 1 to the command bit.
// R15: With the PLL mode enable clear the system dividers run from the reference (bypass mode).
// R16: A divider whose enable is clear keeps its output stopped.
// R17: Reserved bits read as zero and ignore writes; only the multiplier, enable, ratio, mode and command fields are writable.
// The header is guarded, so pulling it in here as well as in the package is harmless.
`include "pll_div_consts.svh"
module pll_multiplier_and_clock_dividers #(
    parameter bit SECOND_INSTANCE = 1'b0,
    parameter int ADDR_W = 8
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst,
    // Register port.
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [31:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rd_data,
    // Clock source enables, one pulse per source clock edge.
    input wire logic ref_tick,
    input wire logic pll_tick,
    // Multiply factor, then clock outputs as one-cycle enables.
    output logic [`FIELD_W:0] pll_multiply_factor,
    output logic system_clock_one,
    output logic system_clock_two,
    output logic system_clock_three,
    output logic observation_clock,
    output logic bypass_system_clock,
    output logic clock_output_pin
);
    import pll_div_pkg::*;

    state_t st;
    state_t next_st;
    logic sys_src;
    logic [`NUM_DIV-1:0] src;

    function automatic logic [31:0] div_word(input logic en, input ratio_t r);
        div_word = {16'h0000, en, 10'h000, r};
    endfunction : div_word

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        hit = (a == ADDR_W'(ofs));
    endfunction : hit

    // R15: bypass selection
    assign sys_src = st.pll_mode ? pll_tick : ref_tick;
    // R4: PLL side feeds system dividers
    // R9: reference feeds observation
    // R12: reference feeds bypass
    assign src = {ref_tick, ref_tick, sys_src, sys_src, sys_src};

    always_comb
    begin
        next_st = st;
        next_st.go = 1'b0;
        next_st.rd_data = 32'h00000000;
        if (wr_en)
        begin
            // R17: only fields are stored
            if (hit(addr, `OFS_MULT))
            begin
                next_st.mult = wr_data[`FIELD_W-1:0];
            end
            for (int i = 0; i < `NUM_DIV; i++)
            begin
                if (hit(addr, 8'(`OFS_DIV_ONE + 4 * i)) && !(SECOND_INSTANCE && i == `DIV_THREE))
                begin
                    next_st.en[i] = wr_data[`ENABLE_BIT];
                    next_st.ratio[i] = wr_data[`FIELD_W-1:0];
                end
            end
            if (hit(addr, `OFS_CLK_ENABLE))
            begin
                next_st.obs_ck_en = wr_data[`OBS_ENABLE_BIT];
            end
            if (hit(addr, `OFS_PLL_CTRL))
            begin
                next_st.pll_mode = wr_data[`PLL_MODE_BIT];
            end
            // The load takes one cycle, so the outputs are not phase aligned to each other.
            // R14: command starts loading
            if (hit(addr, `OFS_COMMAND) && wr_data[`COMMAND_BIT])
            begin
                next_st.go = 1'b1;
            end
        end
        // R1: multiplier is field plus one
        next_st.factor = {1'b0, next_st.mult} + 6'h01;
        // R14: system ratios load on command only
        if (st.go)
        begin
            for (int i = 0; i < `NUM_SYS_DIV; i++)
            begin
                next_st.act[i] = st.ratio[i];
            end
        end
        // Observation and bypass ratios are not phase aligned, so they follow writes at once.
        next_st.act[`DIV_OBS] = next_st.ratio[`DIV_OBS];
        next_st.act[`DIV_BYPASS] = next_st.ratio[`DIV_BYPASS];
        for (int i = 0; i < `NUM_DIV; i++)
        begin
            // R16: disabled divider stays stopped
            if (!st.en[i])
            begin
                next_st.cnt[i] = 5'h00;
                next_st.tick[i] = 1'b0;
            end
            else if (src[i])
            begin
                // R3: divide by ratio plus one
                next_st.tick[i] = (st.cnt[i] >= st.act[i]);
                next_st.cnt[i] = (st.cnt[i] >= st.act[i]) ? 5'h00 : 5'(st.cnt[i] + 5'h01);
            end
            else
            begin
                next_st.tick[i] = 1'b0;
            end
        end
        // R11: observation needs both enables
        if (!st.obs_ck_en)
        begin
            next_st.tick[`DIV_OBS] = 1'b0;
        end
        // R8: third divider absent on instance two
        if (SECOND_INSTANCE)
        begin
            next_st.tick[`DIV_THREE] = 1'b0;
        end
        if (rd_en)
        begin
            // R17: reserved bits read zero
            if (hit(addr, `OFS_MULT))
            begin
                next_st.rd_data = {27'h0000000, st.mult};
            end
            for (int i = 0; i < `NUM_DIV; i++)
            begin
                if (hit(addr, 8'(`OFS_DIV_ONE + 4 * i)))
                begin
                    next_st.rd_data = div_word(st.en[i], st.ratio[i]);
                end
            end
            if (hit(addr, `OFS_CLK_ENABLE))
            begin
                next_st.rd_data = {31'h00000000, st.obs_ck_en};
            end
            if (hit(addr, `OFS_PLL_CTRL))
            begin
                next_st.rd_data = {31'h00000000, st.pll_mode};
            end
            if (hit(addr, `OFS_COMMAND))
            begin
                next_st.rd_data = {31'h00000000, st.go};
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            st <= '0;
            // R2: multiplier reset value
            st.mult <= SECOND_INSTANCE ? `MULT_RST_SECOND : `MULT_RST_FIRST;
            st.factor <= {1'b0, SECOND_INSTANCE ? `MULT_RST_SECOND : `MULT_RST_FIRST} + 6'h01;
            // R5: first divider reset ratio
            st.ratio[`DIV_ONE] <= SECOND_INSTANCE ? `DIV_ONE_RST_SECOND : `DIV_ONE_RST_FIRST;
            st.act[`DIV_ONE] <= SECOND_INSTANCE ? `DIV_ONE_RST_SECOND : `DIV_ONE_RST_FIRST;
            // R7: second divider reset ratio
            st.ratio[`DIV_TWO] <= SECOND_INSTANCE ? `DIV_TWO_RST_SECOND : `DIV_TWO_RST_FIRST;
            st.act[`DIV_TWO] <= SECOND_INSTANCE ? `DIV_TWO_RST_SECOND : `DIV_TWO_RST_FIRST;
            st.ratio[`DIV_THREE] <= `DIV_THREE_RST;
            st.act[`DIV_THREE] <= `DIV_THREE_RST;
            st.ratio[`DIV_OBS] <= `DIV_OBS_RST;
            st.act[`DIV_OBS] <= `DIV_OBS_RST;
            // R13: bypass reset ratio
            st.ratio[`DIV_BYPASS] <= SECOND_INSTANCE ? `BYPASS_RST_SECOND : `BYPASS_RST_FIRST;
            st.act[`DIV_BYPASS] <= SECOND_INSTANCE ? `BYPASS_RST_SECOND : `BYPASS_RST_FIRST;
            // R6: enables set after reset, except the observation one (and the third on instance two)
            // R12: bypass enable set
            st.en <= SECOND_INSTANCE ? (`ENABLE_RST & 5'h1b) : `ENABLE_RST;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign rd_data = st.rd_data;
    assign pll_multiply_factor = st.factor;
    assign system_clock_one = st.tick[`DIV_ONE];
    assign system_clock_two = st.tick[`DIV_TWO];
    assign system_clock_three = st.tick[`DIV_THREE];
    assign observation_clock = st.tick[`DIV_OBS];
    assign bypass_system_clock = st.tick[`DIV_BYPASS];
    // R9: output pin on first instance only
    assign clock_output_pin = SECOND_INSTANCE ? 1'b0 : st.tick[`DIV_OBS];

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    property p_factor;
        $changed(st.mult) |-> st.factor == {1'b0, st.mult} + 6'h01;
    endproperty
    a_factor: assert property (p_factor) else $error("multiply factor is not field plus one"); // R1

    property p_mult_rst;
        $past(rst) |-> st.mult == (SECOND_INSTANCE ? `MULT_RST_SECOND : `MULT_RST_FIRST);
    endproperty
    a_mult_rst: assert property (p_mult_rst) else $error("multiplier reset value wrong"); // R2

    property p_pass;
        (src[`DIV_BYPASS] && st.en[`DIV_BYPASS] && st.act[`DIV_BYPASS] == 5'h00)
            |=> bypass_system_clock;
    endproperty
    a_pass: assert property (p_pass) else $error("ratio zero did not pass clock"); // R3

    property p_div_two;
        (st.en[`DIV_BYPASS] && st.act[`DIV_BYPASS] == 5'h01 && bypass_system_clock && ref_tick
            && !wr_en) |=> !bypass_system_clock;
    endproperty
    a_div_two: assert property (p_div_two) else $error("divide by two pulsed twice"); // R3

    property p_one_write;
        (wr_en && hit(addr, `OFS_DIV_ONE)) |=> st.en[`DIV_ONE] == $past(wr_data[`ENABLE_BIT]);
    endproperty
    a_one_write: assert property (p_one_write) else $error("first enable not stored"); // R4

    property p_rst_ratios;
        $past(rst) |-> st.act[`DIV_ONE] == (SECOND_INSTANCE ? 5'h01 : 5'h00)
            && st.act[`DIV_TWO] == (SECOND_INSTANCE ? 5'h09 : 5'h02)
            && st.act[`DIV_BYPASS] == (SECOND_INSTANCE ? 5'h01 : 5'h00);
    endproperty
    a_rst_ratios: assert property (p_rst_ratios) else $error("divider reset ratio wrong"); // R5 R7 R13

    property p_rst_en;
        $past(rst) |-> st.en[`DIV_TWO] && st.en[`DIV_BYPASS];
    endproperty
    a_rst_en: assert property (p_rst_en) else $error("enable not set after reset"); // R6 R12

    property p_three_absent;
        SECOND_INSTANCE |-> !system_clock_three;
    endproperty
    a_three_absent: assert property (p_three_absent) else $error("third clock on instance two"); // R8

    property p_pin;
        clock_output_pin |-> !SECOND_INSTANCE && observation_clock;
    endproperty
    a_pin: assert property (p_pin) else $error("output pin not the observation clock"); // R9

    property p_obs_gate;
        observation_clock |-> $past(st.en[`DIV_OBS]) && $past(st.obs_ck_en);
    endproperty
    a_obs_gate: assert property (p_obs_gate) else $error("observation clock ran ungated"); // R11

    property p_no_go;
        (!st.go) |=> $stable(st.act[`DIV_ONE]);
    endproperty
    a_no_go: assert property (p_no_go) else $error("ratio changed without command"); // R14

    property p_go;
        (wr_en && hit(addr, `OFS_COMMAND) && wr_data[`COMMAND_BIT] && !rd_en)
            ##1 (!wr_en) |=> st.act[`DIV_TWO] == st.ratio[`DIV_TWO];
    endproperty
    a_go: assert property (p_go) else $error("command did not load ratio"); // R14

    property p_src;
        system_clock_one |-> $past(st.pll_mode ? pll_tick : ref_tick);
    endproperty
    a_src: assert property (p_src) else $error("system clock from wrong source"); // R15

    property p_stop;
        !st.en[`DIV_ONE] |=> !system_clock_one;
    endproperty
    a_stop: assert property (p_stop) else $error("disabled divider pulsed"); // R16

    property p_reserved;
        $past(rd_en) |-> rd_data[31:16] == 16'h0000 && rd_data[14:5] == 10'h000;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits not zero"); // R17

    c_go: cover property (wr_en && hit(addr, `OFS_COMMAND) ##2 system_clock_one);
    c_obs: cover property (observation_clock ##[1:40] observation_clock);
    c_pll: cover property (st.pll_mode && system_clock_two);
    c_bypass: cover property (!st.pll_mode && system_clock_one);
endmodule : pll_multiplier_and_clock_dividers

// File: pll_multiplier_and_clock_dividers_tb_top.sv
`timescale 1ns/100ps
module pll_multiplier_and_clock_dividers_tb_top;
    import pll_div_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wr_data = 32'h0;
    logic wr_en = 1'b0;
    logic wr_two = 1'b0;
    logic rd_en = 1'b0;
    logic ref_tick = 1'b0;
    logic pll_tick = 1'b0;
    logic [31:0] rd_data;
    logic [31:0] rd_data_two;
    logic [5:0] factor;
    logic [5:0] factor_two;
    logic [4:0] outs;
    logic pin;
    logic [1:0] outs_two;
    int err_total = 0;
    int compares = 0;
    logic [31:0] rst_one [9] = '{32'h10, 32'h8000, 32'h8002, 32'h8000, 0, 32'h8000, 0, 0, 0};
    logic [31:0] rst_two [9] = '{32'h13, 32'h8001, 32'h8009, 0, 0, 32'h8001, 0, 0, 0};
    int old [3] = '{1, 3, 1};

    initial
    begin
        forever #2.5 clk_sys = ~clk_sys;
    end

    pll_multiplier_and_clock_dividers #(.SECOND_INSTANCE(1'b0)) dut (
        .clk_sys(clk_sys), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .ref_tick(ref_tick), .pll_tick(pll_tick),
        .pll_multiply_factor(factor), .system_clock_one(outs[0]), .system_clock_two(outs[1]),
        .system_clock_three(outs[2]), .observation_clock(outs[3]),
        .bypass_system_clock(outs[4]), .clock_output_pin(pin)
    );

    // The second instance only sees software that leaves its observation divider alone.
    // observation divider untouched
    pll_multiplier_and_clock_dividers #(.SECOND_INSTANCE(1'b1)) dut_two (
        .clk_sys(clk_sys), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_two),
        .rd_en(rd_en), .rd_data(rd_data_two), .ref_tick(ref_tick), .pll_tick(pll_tick),
        .pll_multiply_factor(factor_two), .system_clock_one(), .system_clock_two(),
        .system_clock_three(outs_two[0]), .observation_clock(), .bypass_system_clock(),
        .clock_output_pin(outs_two[1])
    );

    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task wr(input bit two, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        wr_data <= d;
        if (two) wr_two <= 1'b1;
        else wr_en <= 1'b1;
        @(posedge clk_sys);
        wr_en <= 1'b0;
        wr_two <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, output logic [31:0] d1, output logic [31:0] d2);
        @(posedge clk_sys);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1;
        d1 = rd_data;
        d2 = rd_data_two;
    endtask : rd

    // Skips the first two, possibly partial, intervals; zero means no pulse within the bound.
    task period(input int sel, output int p);
        int n;
        p = 0;
        repeat (3)
        begin
            n = 0;
            do
            begin
                @(posedge clk_sys);
                #1;
                n++;
            end while (outs[sel] !== 1'b1 && n < 100);
            p = (n < 100) ? n : 0;
        end
    endtask : period

    task complete_run();
        $display("Checks %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : complete_run

    always @(negedge clk_sys)
    begin
        if (pin !== outs[3])
        begin
            err_total++;
            $display("BAD %0t output pin differs", $time);
        end
        if (!rst && outs_two !== 2'b00)
        begin
            err_total++;
            $display("BAD %0t second instance pulsed third clock or pin", $time);
        end
    end

    initial
    begin
        logic [31:0] d1;
        logic [31:0] d2;
        logic [31:0] v;
        logic [31:0] mv;
        int p;
        int r [3];
        void'($urandom(23));
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        for (int i = 0; i < 9; i++)
        begin
            rd(8'(i * 4), d1, d2);
            chk(d1, rst_one[i], "reset first");
            chk(d2, rst_two[i], "reset second");
        end
        chk({26'h0, factor}, 32'd17, "factor first");
        chk({26'h0, factor_two}, 32'd20, "factor second");
        for (int i = 0; i < 6; i++)
        begin
            v = $urandom;
            wr(0, 8'(i * 4), v);
            if (i == 0)
                mv = v;
            rd(8'(i * 4), d1, d2);
            chk(d1, v & ((i == 0) ? 32'h1f : 32'h801f), "write mask");
        end
        chk({26'h0, factor}, {27'h0, mv[4:0]} + 32'd1, "factor written");
        wr(0, 8'h00, 32'h0000001f);
        @(posedge clk_sys);
        #1;
        chk({26'h0, factor}, 32'd32, "factor max");
        wr(0, 8'h40, 32'hffffffff);
        rd(8'h40, d1, d2);
        chk(d1, 32'h0, "unmapped");
        wr(1, 8'h0c, 32'h0000801f);
        rd(8'h0c, d1, d2);
        chk(d2, 32'h0, "third on second");
        for (int i = 1; i < 4; i++)
            wr(0, 8'(i * 4), rst_one[i]);
        ref_tick <= 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            v = (k == 3) ? 32'h1f : $urandom_range(7);
            wr(0, 8'h14, 32'h8000 | v);
            period(4, p);
            chk(32'(p), v + 1, "bypass period");
        end
        wr(0, 8'h14, 32'h0000001);
        period(4, p);
        chk(32'(p), 32'd0, "bypass off");
        wr(0, 8'h10, 32'h00008002);
        period(3, p);
        chk(32'(p), 32'd0, "obs gated");
        wr(0, 8'h18, 32'h00000001);
        period(3, p);
        chk(32'(p), 32'd3, "obs period");
        period(0, p);
        chk(32'(p), 32'd1, "bypass mode one");
        period(1, p);
        chk(32'(p), 32'd3, "bypass mode two");
        wr(0, 8'h1c, 32'h00000001);
        period(0, p);
        chk(32'(p), 32'd0, "pll idle");
        pll_tick <= 1'b1;
        for (int s = 0; s < 3; s++)
        begin
            r[s] = $urandom_range(7, 1);
            wr(0, 8'(4 + 4 * s), 32'h8000 | r[s]);
            period(s, p);
            chk(32'(p), 32'(old[s]), "before command");
        end
        wr(0, 8'h20, 32'h00000001);
        for (int s = 0; s < 3; s++)
        begin
            period(s, p);
            chk(32'(p), 32'(r[s] + 1), "after command");
        end
        wr(0, 8'h08, 32'h00000002);
        period(1, p);
        chk(32'(p), 32'd0, "second off");
        complete_run();
    end
endmodule : pll_multiplier_and_clock_dividers_tb_top
